// ---- hw/scss_clock_map.vh ----
// Register offsets, field positions, mode codes and timing counts of the clock selector
`ifndef SCSS_CLOCK_MAP_VH
`define SCSS_CLOCK_MAP_VH

// Register offsets on the plain register port
`define SCSS_ADDR_W 2
`define SCSS_REG_CONFIG 2'h0
`define SCSS_REG_CONTROL 2'h1
`define SCSS_REG_STATUS 2'h2

// Configuration register layout
`define SCSS_CFG_MODE_HI 2
`define SCSS_CFG_MODE_LO 0
`define SCSS_CFG_POWERUP_BIT 3
`define SCSS_CFG_SPEED_BIT 7
`define SCSS_CFG_RESET 8'h0b

// Control register layout
`define SCSS_CTL_SLEEP_BIT 0

// Status register layout
`define SCSS_STS_STATE_HI 4
`define SCSS_STS_STATE_LO 0
`define SCSS_STS_MODE_HI 7
`define SCSS_STS_MODE_LO 5

// Clock source field codes, one per mode
`define SCSS_MODE_LOW_GAIN 3'h0
`define SCSS_MODE_MED_GAIN 3'h1
`define SCSS_MODE_HIGH_GAIN 3'h2
`define SCSS_MODE_EXT_CLOCK 3'h3
`define SCSS_MODE_ONCHIP_FREE 3'h4
`define SCSS_MODE_ONCHIP_DIV 3'h5
`define SCSS_MODE_RESCAP_PIN 3'h6
`define SCSS_MODE_RESCAP_DIV 3'h7

// Amplifier gain codes
`define SCSS_GAIN_OFF 2'h0
`define SCSS_GAIN_LOW 2'h1
`define SCSS_GAIN_MED 2'h2
`define SCSS_GAIN_HIGH 2'h3

// Start-up counts
`define SCSS_CNT_W 16
`define SCSS_STARTUP_EDGES 16'h0400
`define SCSS_INSTR_CLKS 16'h0004
`define SCSS_EXT_INSTR 16'h0002
`define SCSS_POWERUP_DEFAULT 16'h0400
`define SCSS_WARM_DEFAULT 16'h0028
`define SCSS_CNT_ONE 16'h0001
`define SCSS_CNT_ZERO 16'h0000

`endif

// ---- hw/scss_clock_select.v ----
// Clock source selection, pin release and start-up hold logic
`timescale 1ns/1ps
`include "scss_clock_map.vh"

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R01: Eight modes from three-bit source field
// R02: External clock: pin clock, output pin free
// R03: External clock mode skips the oscillation counter
// R04: Fully static; stopped clock keeps state
// R05: Crystal modes count 1024 input oscillations
// R06: Execution held while start-up counting
// R07: Source change waits source-dependent stabilisation
// R08: Crystal modes drive low/medium/high gain
// R09: Low gain mode is the watch crystal
// R10: Resistor-capacitor divided mode drives clock by four
// R11: Resistor-capacitor pin mode frees output pin
// R12: On-chip divided: output by four, input free
// R13: On-chip free mode releases both pins
// R14: On-chip clock 4 MHz postscaled or 8 MHz
// R15: One configuration bit picks on-chip speed
// R16: Each mode owns one distinct field code
module scss_clock_select #(
	parameter [15:0] POWERUP_CYCLES = `SCSS_POWERUP_DEFAULT,
	parameter [15:0] WARM_CYCLES = `SCSS_WARM_DEFAULT
)(
	input wire mclk,
	input wire resetn,
	input wire [1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire clock_input_pin,
	input wire wake_pin,
	output reg exec_enable,
	output reg [1:0] amp_gain,
	output reg watch_crystal_sel,
	output reg onchip_osc_sel,
	output reg postscaler_bypass,
	output reg clock_input_pin_free,
	output reg clock_output_pin_free,
	output reg clock_output_pin_oe,
	output reg clock_output_pin_out,
	output reg sleeping
);

	//////////////////////////////////////////////////////////////////////////
	// States, one-hot
	localparam [4:0] ST_POWERUP = 5'h01; // Power-up delay timer running
	localparam [4:0] ST_STARTUP = 5'h02; // Counting crystal oscillations
	localparam [4:0] ST_WAIT = 5'h04; // Fixed stabilisation wait
	localparam [4:0] ST_RUN = 5'h08; // Execution allowed
	localparam [4:0] ST_SLEEP = 5'h10; // Halted until wake

	//////////////////////////////////////////////////////////////////////////
	// Storage
	reg [7:0] cfg; // Configuration word image
	reg [4:0] state; // Start-up sequencer state
	reg [15:0] cnt; // Shared delay counter
	reg [1:0] div; // Divide-by-4 of the system clock
	reg osc_s1; // Pin clock, first sync stage
	reg osc_s2; // Pin clock, second sync stage
	reg osc_prev; // Pin clock, edge history
	reg wake_s1; // Wake pin, first sync stage
	reg wake_s2; // Wake pin, second sync stage

	reg [4:0] next_state;
	reg [15:0] next_cnt;
	reg [7:0] next_rdata;

	wire [2:0] mode = cfg[`SCSS_CFG_MODE_HI:`SCSS_CFG_MODE_LO];
	wire [2:0] wr_mode = reg_wdata[`SCSS_CFG_MODE_HI:`SCSS_CFG_MODE_LO];
	wire cfg_wr = reg_wr && (reg_addr == `SCSS_REG_CONFIG);
	wire ctl_wr = reg_wr && (reg_addr == `SCSS_REG_CONTROL);
	wire sleep_req = ctl_wr && reg_wdata[`SCSS_CTL_SLEEP_BIT];
	wire osc_edge = osc_s2 && !osc_prev; // Rising edge of the pin clock

	// Mode whose delay applies: a new mode written now wins
	wire [2:0] dly_mode = cfg_wr ? wr_mode : mode;

	//////////////////////////////////////////////////////////////////////////
	// Mode decode
	wire is_crystal = (dly_mode == `SCSS_MODE_LOW_GAIN) ||
		(dly_mode == `SCSS_MODE_MED_GAIN) ||
		(dly_mode == `SCSS_MODE_HIGH_GAIN); // [R05]
	wire is_onchip = (dly_mode == `SCSS_MODE_ONCHIP_FREE) ||
		(dly_mode == `SCSS_MODE_ONCHIP_DIV);

	// Fixed wait length: on-chip warm-up, else two instruction cycles
	// Product kept at full width, then cut on purpose to the counter width
	localparam [31:0] EXT_WAIT_FULL = `SCSS_EXT_INSTR * `SCSS_INSTR_CLKS;
	wire [15:0] ext_wait = EXT_WAIT_FULL[15:0];
	wire [15:0] wait_len = is_onchip ? WARM_CYCLES : ext_wait; // [R07]

	// Crystal sources count pin edges; the rest wait a fixed time
	wire [4:0] delay_state = is_crystal ? ST_STARTUP : ST_WAIT; // [R03] [R05]

	//////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for the pin clock and wake pin
	// The pin clock is only sampled, so it must stay well below half of mclk
	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
			osc_prev <= 1'b0;
			wake_s1 <= 1'b0;
			wake_s2 <= 1'b0;
		end
		else
		begin
			osc_s1 <= clock_input_pin;
			osc_s2 <= osc_s1;
			osc_prev <= osc_s2; // Edge detect looks only at the second stage
			wake_s1 <= wake_pin;
			wake_s2 <= wake_s1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Configuration register
	// Static logic: if mclk stops everything here simply holds [R04]
	always @(posedge mclk)
	begin
		if (!resetn)
			cfg <= `SCSS_CFG_RESET;
		else if (cfg_wr)
			cfg <= reg_wdata; // [R01] [R15]
	end

	//////////////////////////////////////////////////////////////////////////
	// Start-up sequencer, next state
	always @*
	begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			ST_POWERUP:
			begin
				// Power-up delay first when enabled, then the source delay
				if (!cfg[`SCSS_CFG_POWERUP_BIT] || cnt >= POWERUP_CYCLES)
				begin
					next_state = delay_state; // [R05]
					next_cnt = `SCSS_CNT_ZERO;
				end
				else
					next_cnt = cnt + `SCSS_CNT_ONE;
			end
			ST_STARTUP:
			begin
				// Count oscillations seen on the input pin
				if (cnt >= `SCSS_STARTUP_EDGES)
				begin
					next_state = ST_RUN; // [R05]
					next_cnt = `SCSS_CNT_ZERO;
				end
				else if (osc_edge)
					next_cnt = cnt + `SCSS_CNT_ONE; // [R05]
			end
			ST_WAIT:
			begin
				// Fixed stabilisation wait in system clocks
				if (cnt >= wait_len)
				begin
					next_state = ST_RUN; // [R07]
					next_cnt = `SCSS_CNT_ZERO;
				end
				else
					next_cnt = cnt + `SCSS_CNT_ONE;
			end
			ST_RUN:
			begin
				// Software may put the device to sleep
				if (sleep_req)
					next_state = ST_SLEEP;
			end
			ST_SLEEP:
			begin
				// Wake restarts the source delay
				if (wake_s2)
				begin
					next_state = delay_state; // [R05] [R07]
					next_cnt = `SCSS_CNT_ZERO;
				end
			end
			default:
			begin
				next_state = ST_POWERUP;
				next_cnt = `SCSS_CNT_ZERO;
			end
		endcase
		// A new source restarts the stabilisation delay
		// In power-up or sleep the word is only stored; the stored
		// mode's delay then runs when that state ends
		if (cfg_wr && wr_mode != mode && state != ST_POWERUP && state != ST_SLEEP)
		begin
			next_state = delay_state; // [R07]
			next_cnt = `SCSS_CNT_ZERO;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Start-up sequencer, registers
	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			state <= ST_POWERUP;
			cnt <= `SCSS_CNT_ZERO;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Divide-by-4 of the system clock for the output pin
	// Free-running, so a mode change never restarts the output phase
	always @(posedge mclk)
	begin
		if (!resetn)
			div <= 2'h0;
		else
			div <= div + 2'h1; // [R10] [R12]
	end

	//////////////////////////////////////////////////////////////////////////
	// Execution hold: program counter frozen outside the run state
	// Taken from the next state so the hold ends on the edge that enters run
	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			exec_enable <= 1'b0;
			sleeping <= 1'b0;
		end
		else
		begin
			exec_enable <= (next_state == ST_RUN); // [R06]
			sleeping <= (next_state == ST_SLEEP);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Source, gain and pin use per mode
	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			amp_gain <= `SCSS_GAIN_OFF;
			watch_crystal_sel <= 1'b0;
			onchip_osc_sel <= 1'b0;
			postscaler_bypass <= 1'b0;
			clock_input_pin_free <= 1'b0;
			clock_output_pin_free <= 1'b0;
			clock_output_pin_oe <= 1'b0;
			clock_output_pin_out <= 1'b0;
		end
		else
		begin
			// Defaults: pin clock, amplifier off, pins owned by the oscillator
			amp_gain <= `SCSS_GAIN_OFF;
			watch_crystal_sel <= 1'b0;
			onchip_osc_sel <= 1'b0;
			postscaler_bypass <= cfg[`SCSS_CFG_SPEED_BIT]; // [R14] [R15]
			clock_input_pin_free <= 1'b0;
			clock_output_pin_free <= 1'b0;
			clock_output_pin_oe <= 1'b0;
			clock_output_pin_out <= 1'b0;
			case (mode) // [R01] [R16]
				`SCSS_MODE_LOW_GAIN:
				begin
					// Watch crystal, weakest drive
					amp_gain <= `SCSS_GAIN_LOW; // [R08]
					watch_crystal_sel <= 1'b1; // [R09]
				end
				`SCSS_MODE_MED_GAIN:
					amp_gain <= `SCSS_GAIN_MED; // [R08]
				`SCSS_MODE_HIGH_GAIN:
					amp_gain <= `SCSS_GAIN_HIGH; // [R08]
				`SCSS_MODE_EXT_CLOCK:
					clock_output_pin_free <= 1'b1; // [R02]
				`SCSS_MODE_RESCAP_PIN:
					clock_output_pin_free <= 1'b1; // [R11]
				`SCSS_MODE_RESCAP_DIV:
				begin
					clock_output_pin_oe <= 1'b1; // [R10]
					clock_output_pin_out <= div[1]; // [R10]
				end
				`SCSS_MODE_ONCHIP_DIV:
				begin
					onchip_osc_sel <= 1'b1; // [R14]
					clock_input_pin_free <= 1'b1; // [R12]
					clock_output_pin_oe <= 1'b1; // [R12]
					clock_output_pin_out <= div[1]; // [R12]
				end
				`SCSS_MODE_ONCHIP_FREE:
				begin
					onchip_osc_sel <= 1'b1; // [R14]
					clock_input_pin_free <= 1'b1; // [R13]
					clock_output_pin_free <= 1'b1; // [R13]
				end
				default:
					amp_gain <= `SCSS_GAIN_OFF;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Register read path, data valid the cycle after the strobe only
	always @*
	begin
		next_rdata = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				`SCSS_REG_CONFIG:
					next_rdata = cfg;
				`SCSS_REG_STATUS:
				begin
					next_rdata[`SCSS_STS_STATE_HI:`SCSS_STS_STATE_LO] = state;
					next_rdata[`SCSS_STS_MODE_HI:`SCSS_STS_MODE_LO] = mode;
				end
				default:
					next_rdata = 8'h00; // Control and unmapped read zero
			endcase
		end
	end

	// Read data register, zero outside the answer cycle
	always @(posedge mclk)
	begin
		if (!resetn)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= next_rdata;
	end

endmodule

// ---- dv/scss_xtal_model.sv ----
// Crystal or resonator seen on the clock input pin
`timescale 1ns/1ps
module scss_xtal_model #(
	parameter HALF_NS = 110
)(
	input wire run,
	output reg osc
);
	// A stopped crystal rests low rather than holding its last phase
	initial osc = 1'b0;
	// Free oscillation while powered, slower than mclk
	always
	begin
		#HALF_NS;
		osc = run ? ~osc : 1'b0;
	end
endmodule

// ---- dv/scss_properties.sv ----
// Port checker for the clock source selector
`timescale 1ns/1ps
`include "scss_clock_map.vh"
module scss_properties (
	input wire mclk,
	input wire resetn,
	input wire exec_enable,
	input wire [1:0] amp_gain,
	input wire watch_crystal_sel,
	input wire onchip_osc_sel,
	input wire clock_input_pin_free,
	input wire clock_output_pin_free,
	input wire clock_output_pin_oe,
	input wire clock_output_pin_out,
	input wire sleeping
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// Cycles spent held, saturating so it never wraps
	reg [3:0] held;
	always @(posedge mclk)
		if (!resetn || exec_enable)
			held <= 4'h0;
		else if (held != 4'hf)
			held <= held + 4'h1;
	AST_WATCH_LOW_GAIN: assert property (watch_crystal_sel == (amp_gain == `SCSS_GAIN_LOW))
		else $error("watch crystal select disagrees with gain");
	AST_ONCHIP_INPUT_FREE: assert property (clock_input_pin_free == onchip_osc_sel)
		else $error("input pin release disagrees with on-chip mode");
	AST_ONCHIP_NO_GAIN: assert property (onchip_osc_sel |-> amp_gain == `SCSS_GAIN_OFF)
		else $error("amplifier on in on-chip mode");
	AST_DRIVE_NOT_FREE: assert property (clock_output_pin_oe |->
		!clock_output_pin_free && amp_gain == `SCSS_GAIN_OFF)
		else $error("divided output on a free or crystal pin");
	AST_IDLE_OUT_LOW: assert property (!clock_output_pin_oe |-> !clock_output_pin_out)
		else $error("output pin toggles while released");
	AST_DIV_FOUR: assert property (clock_output_pin_oe && $past(clock_output_pin_oe) &&
		$past(clock_output_pin_oe, 2) |-> clock_output_pin_out != $past(clock_output_pin_out, 2))
		else $error("divided clock is not a quarter of mclk");
	AST_SLEEP_HOLDS: assert property (sleeping |-> !exec_enable)
		else $error("execution runs while asleep");
	AST_START_DELAY: assert property ($rose(exec_enable) |-> held >= 4'h5)
		else $error("execution released without stabilisation delay");
endmodule
bind scss_clock_select scss_properties u_props (.mclk(mclk), .resetn(resetn),
	.exec_enable(exec_enable), .amp_gain(amp_gain), .watch_crystal_sel(watch_crystal_sel),
	.onchip_osc_sel(onchip_osc_sel), .clock_input_pin_free(clock_input_pin_free),
	.clock_output_pin_free(clock_output_pin_free), .clock_output_pin_oe(clock_output_pin_oe),
	.clock_output_pin_out(clock_output_pin_out), .sleeping(sleeping));

// ---- dv/scss_tb.sv ----
// Self-checking bench for the clock source selector
`timescale 1ns/1ps
`include "scss_clock_map.vh"
module testbench;
	reg mclk, resetn, reg_wr, reg_rd, wake_pin, xtal_run, on;
	reg [1:0] reg_addr;
	reg [7:0] reg_wdata, q;
	wire [7:0] reg_rdata;
	wire osc, exec_enable, watch, onchip, in_free, out_free, oe, out, bypass, sleeping;
	wire [1:0] amp_gain;
	integer mismatches = 0, tests_run = 0, edges = 0, m;
	scss_xtal_model u_xtal (.run(xtal_run), .osc(osc));
	// Short power-up and warm-up counts keep the run brief
	scss_clock_select #(.POWERUP_CYCLES(16'h0008), .WARM_CYCLES(16'h0004)) u_dut (
		.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clock_input_pin(osc),
		.wake_pin(wake_pin), .exec_enable(exec_enable), .amp_gain(amp_gain),
		.watch_crystal_sel(watch), .onchip_osc_sel(onchip), .postscaler_bypass(bypass),
		.clock_input_pin_free(in_free), .clock_output_pin_free(out_free),
		.clock_output_pin_oe(oe), .clock_output_pin_out(out), .sleeping(sleeping));
	// 50 ns period
	always #25 mclk = ~mclk;
	// Crystal oscillations seen since last cleared
	always @(posedge osc) edges = edges + 1;
	task chk(input [7:0] e, input [7:0] g, input string what);
		begin
			tests_run = tests_run + 1;
			if (g !== e)
			begin
				mismatches = mismatches + 1;
				$display("wrong value %0s expected %h seen %h", what, e, g);
			end
		end
	endtask
	task wr(input [1:0] a, input [7:0] d);
		begin
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge mclk);
			reg_wr <= 1'b0;
		end
	endtask
	// Read data is valid only in the cycle after the strobe
	task rd(input [1:0] a, output [7:0] d);
		begin
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge mclk);
			reg_rd <= 1'b0;
			#1 d = reg_rdata;
			@(posedge mclk);
		end
	endtask
	// Bounded wait for execution to be released
	task wait_exec(input integer lim);
		integer n;
		begin
			n = 0;
			while (exec_enable !== 1'b1 && n < lim)
			begin
				@(posedge mclk);
				n = n + 1;
			end
			chk(8'h1, {7'h0, exec_enable}, "exec");
		end
	endtask
	// Reset values, unmapped read, prompt start in external clock mode
	task t_reset;
		begin
			rd(`SCSS_REG_CONFIG, q);
			chk(`SCSS_CFG_RESET, q, "config");
			rd(`SCSS_REG_STATUS, q);
			chk(8'h61, q, "status");
			rd(2'h3, q);
			chk(8'h00, q, "unmapped");
			wait_exec(30);
			chk(8'h02, {3'h0, amp_gain, in_free, out_free, oe}, "ext pins");
		end
	endtask
	// Every mode code with its pin, gain and speed outputs
	task t_modes;
		begin
			for (m = 0; m < 8; m = m + 1)
			begin
				wr(`SCSS_REG_CONFIG, {m[0], 4'h0, m[2:0]});
				rd(`SCSS_REG_CONFIG, q);
				chk({m[0], 4'h0, m[2:0]}, q, "config rw");
				rd(`SCSS_REG_STATUS, q);
				chk({5'h0, m[2:0]}, {5'h0, q[7:5]}, "status mode");
				on = (m == 4) || (m == 5);
				chk({(m < 3) ? m[1:0] + 2'h1 : `SCSS_GAIN_OFF, m == 0, on, on,
					m == 3 || m == 4 || m == 6, m == 5 || m == 7, m[0]},
					{amp_gain, watch, onchip, in_free, out_free, oe, bypass}, "mode pins");
			end
		end
	endtask
	// Crystal start-up after a mode change and after wake from sleep
	task t_sleep;
		begin
			xtal_run = 1'b1;
			edges = 0;
			wr(`SCSS_REG_CONFIG, {5'h0, `SCSS_MODE_HIGH_GAIN});
			wait_exec(8000);
			chk(8'h1, {7'h0, edges >= 1024 && edges < 1028}, "osc count");
			wr(`SCSS_REG_CONTROL, 8'h01);
			repeat (3) @(posedge mclk);
			chk(8'h1, {7'h0, sleeping & ~exec_enable}, "sleep hold");
			xtal_run = 1'b0;
			repeat (40) @(posedge mclk);
			wake_pin <= 1'b1;
			xtal_run = 1'b1;
			edges = 0;
			wait_exec(8000);
			chk(8'h1, {7'h0, edges >= 1024 && edges < 1028}, "wake count");
			wake_pin <= 1'b0;
		end
	endtask
	task results;
		begin
			if (mismatches == 0 && tests_run > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	// Main sequence
	initial
	begin
		mclk = 1'b0;
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 2'h0;
		reg_wdata = 8'h00;
		wake_pin = 1'b0;
		xtal_run = 1'b0;
		repeat (20) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		t_reset;
		t_modes;
		t_sleep;
		results;
	end
	// Watchdog, well beyond the expected run
	initial
	begin
		#2000000;
		mismatches = mismatches + 1;
		results;
	end
endmodule
